/* File: rtl/tfi_telemetry.v */
// Summary of operation
// (RULE1) DAC word equal to setpoint means CV; lower means CC or CP by knee.
// (RULE2) DAC word reads as 5 V plus high*100 mV minus low*10 mV.
// (RULE3) Enabled fault on idle bus pulls clock line low 50 us at once.
// (RULE4) Fault during a transfer waits for its end, ~22 us, then 50 us low.
// (RULE5) Only masked-in faults signal; trigger clears enables until host rewrites.
// (RULE6) Mask readback survives a trigger and changes only on mask rewrite.
// (RULE7) Mask bit 6 flags secondary waiting for primary handshake.
// (RULE8) Mask bits 0..8: OV, UV, short, sense short, timer, latch, wait, switch, mode.
// (RULE9) Faults set to no response still pulse the clock line when enabled.
// (RULE10) Disable-output faults reset the system; host should not enable them.
// (RULE11) Output voltage reads as 12-bit count of 10 mV.
// (RULE12) Voltage steps coarsen with range, from 20 mV up to 100 mV.
// (RULE13) Word registers are sent low byte first, then high byte.
// (RULE14) Current code is relative to threshold, 192 means 100 percent.
// (RULE15) Host strips the odd parity bit in the current high byte.
// (RULE16) Averages are 16-sample rolling means at instantaneous resolution.
// (RULE17) Opening the bus switch clears averages, which then rebuild.
// (RULE18) Voltage and current registers refresh every 100 us.
// (RULE19) Bus service stops while logic supply is below reset threshold.
// (RULE20) Hosts without asymmetric clocking should stay at or below 535 kHz.
`include "tfi_map.vh"
module tfi_telemetry #(
  parameter SAMPLE_CYC = `TFI_SAMPLE_NS / `TFI_CLK_NS,
  parameter PULL_CYC   = (`TFI_PULL_NS + `TFI_CLK_NS - 1) / `TFI_CLK_NS,
  parameter QUIET_CYC  = (`TFI_QUIET_NS + `TFI_CLK_NS - 1) / `TFI_CLK_NS
) (
  input  wire                   clk,
  input  wire                   sys_rst,
  input  wire                   sclIn,
  output reg                    sclOut,
  output reg                    sclOe,
  input  wire                   sdaIn,
  output reg                    sdaOut,
  output reg                    sdaOe,
  input  wire                   supplyOk,
  input  wire [15:0]            dacWord,
  input  wire [15:0]            setpointWord,
  input  wire [11:0]            kneeVoltage,
  input  wire [11:0]            voltSample,
  input  wire [7:0]             currSample,
  input  wire                   busSwitchOpen,
  input  wire [`TFI_MASK_W-2:0] faultEvent,
  output reg  [1:0]             opMode
);

  // Counter end points, cut to the 16-bit counters on purpose.
  localparam integer SAMPLE_M1   = SAMPLE_CYC - 1;
  localparam integer PULL_M1     = PULL_CYC - 1;
  localparam integer QUIET_M1    = QUIET_CYC - 1;
  localparam [15:0]  SAMPLE_LAST = SAMPLE_M1[15:0];
  localparam [15:0]  PULL_LAST   = PULL_M1[15:0];
  localparam [15:0]  QUIET_LAST  = QUIET_M1[15:0];

  localparam [2:0] I_IDLE = 3'h0;
  localparam [2:0] I_ADDR = 3'h1;
  localparam [2:0] I_AACK = 3'h2;
  localparam [2:0] I_WR   = 3'h3;
  localparam [2:0] I_WACK = 3'h4;
  localparam [2:0] I_RD   = 3'h5;
  localparam [2:0] I_RACK = 3'h6;

  localparam [1:0] N_IDLE  = 2'h0;
  localparam [1:0] N_QUIET = 2'h1;
  localparam [1:0] N_PULL  = 2'h2;

  // DAC word to 10 mV units.
  function [12:0] dac_level;
    input [15:0] w;
    begin
      dac_level = `TFI_DAC_BASE + {5'h00, w[15:8]} * `TFI_DAC_HI_STEP
                  - {5'h00, w[7:0]}; // RULE2
    end
  endfunction

  // Odd parity over the high byte, carried in its top bit.
  function [15:0] curr_word;
    input [7:0] c;
    begin
      curr_word = {~(^7'h00), 7'h00, c}; // RULE14
    end
  endfunction

  // Drop precision as the voltage range rises.
  function [11:0] quantize;
    input [11:0] v;
    begin
      if (v < `TFI_V_LO)
        quantize = {v[11:1], 1'b0};
      else if (v < `TFI_V_MID)
        quantize = {v[11:2], 2'h0};
      else
        quantize = v - (v % `TFI_V_HI_STEP);
    end
  endfunction

  wire [2:0] syncOut;
  wire       sclS = syncOut[2];
  wire       sdaS = syncOut[1];
  wire       okS  = syncOut[0];

  tfi_sync #(
    .W (3)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     ({sclIn, sdaIn, supplyOk}),
    .dout    (syncOut)
  );

  reg                    sclP;
  reg                    sdaP;
  reg                    busBusy;
  reg [2:0]              iState;
  reg [3:0]              bitCnt;
  reg [7:0]              shiftIn;
  reg [7:0]              txByte;
  reg                    rnw;
  reg                    ackOn;
  reg                    nack;
  reg [1:0]              wrIdx;
  reg [7:0]              cmd;
  reg [7:0]              ptr;
  reg                    hiByte;
  reg                    wrStbLo;
  reg                    wrStbHi;
  reg [7:0]              wrData;
  reg [15:0]             sampCnt;
  reg                    sampTick;
  reg [15:0]             currInst;
  reg [11:0]             voltInst;
  reg [`TFI_MASK_W-1:0]  maskEn;
  reg [`TFI_MASK_W-1:0]  maskRd;
  reg                    pending;
  reg                    deferred;
  reg [1:0]              nState;
  reg [15:0]             nCnt;
  reg [15:0]             curWord;
  reg [1:0]              next_opMode;

  wire sclRise = sclS & ~sclP;
  wire sclFall = ~sclS & sclP;
  wire startC  = sclS & sclP & sdaP & ~sdaS;
  wire stopC   = sclS & sclP & ~sdaP & sdaS;
  wire [7:0]  byteIn  = {shiftIn[6:0], sdaS};
  wire [7:0]  nextTx  = hiByte ? curWord[15:8] : curWord[7:0];
  wire [11:0] cAvg;
  wire [11:0] vAvg;

  // Register read decode; unmapped offsets read as zero.
  always @*
  begin
    case (ptr)
      `TFI_REG_SETPT:  curWord = setpointWord;
      `TFI_REG_CURR:   curWord = currInst;
      `TFI_REG_VOLT:   curWord = {4'h0, voltInst}; // RULE11
      `TFI_REG_MODE:   curWord = {14'h0000, opMode};
      `TFI_REG_CAVG:   curWord = curr_word(cAvg[7:0]); // RULE16
      `TFI_REG_VAVG:   curWord = {4'h0, vAvg};
      `TFI_REG_DAC:    curWord = dacWord; // RULE2
      `TFI_REG_MASKRD: curWord = {7'h00, maskRd};
      default:         curWord = 16'h0000;
    endcase
  end

  // Bus slave. It never stretches the clock, so SCL is left to the host
  // except while a fault pulse is being sent.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sclP    <= 1'b1;
      sdaP    <= 1'b1;
      busBusy <= 1'b0;
      iState  <= I_IDLE;
      bitCnt  <= 4'h0;
      shiftIn <= 8'h00;
      txByte  <= 8'h00;
      rnw     <= 1'b0;
      ackOn   <= 1'b0;
      nack    <= 1'b0;
      wrIdx   <= 2'h0;
      cmd     <= 8'h00;
      ptr     <= 8'h00;
      hiByte  <= 1'b0;
      wrStbLo <= 1'b0;
      wrStbHi <= 1'b0;
      wrData  <= 8'h00;
      sdaOe   <= 1'b0;
      sdaOut  <= 1'b0;
    end
    else
    begin
      sclP    <= sclS;
      sdaP    <= sdaS;
      wrStbLo <= 1'b0;
      wrStbHi <= 1'b0;
      if (!okS)
      begin
        busBusy <= 1'b0; // RULE19
        iState  <= I_IDLE;
        sdaOe   <= 1'b0;
      end
      else if (startC)
      begin
        busBusy <= 1'b1;
        iState  <= I_ADDR;
        bitCnt  <= 4'h0;
        wrIdx   <= 2'h0;
        hiByte  <= 1'b0;
        sdaOe   <= 1'b0;
      end
      else if (stopC)
      begin
        busBusy <= 1'b0;
        iState  <= I_IDLE;
        sdaOe   <= 1'b0;
      end
      else
      begin
        case (iState)
          I_ADDR:
          begin
            if (sclRise)
            begin
              shiftIn <= byteIn;
              bitCnt  <= bitCnt + 4'h1;
              if (bitCnt == 4'h7)
              begin
                bitCnt <= 4'h0;
                rnw    <= byteIn[0];
                ackOn  <= 1'b0;
                iState <= (byteIn[7:1] == `TFI_DEV_ADDR) ? I_AACK : I_IDLE;
              end
            end
          end
          I_AACK, I_WACK:
          begin
            if (sclFall)
            begin
              if (!ackOn)
              begin
                ackOn <= 1'b1;
                sdaOe <= 1'b1;
              end
              else if (rnw && iState == I_AACK)
              begin
                ackOn  <= 1'b0;
                txByte <= nextTx; // RULE13
                sdaOe  <= ~nextTx[7];
                iState <= I_RD;
              end
              else
              begin
                ackOn  <= 1'b0;
                sdaOe  <= 1'b0;
                iState <= I_WR;
              end
            end
          end
          I_WR:
          begin
            if (sclRise)
            begin
              shiftIn <= byteIn;
              bitCnt  <= bitCnt + 4'h1;
              if (bitCnt == 4'h7)
              begin
                bitCnt <= 4'h0;
                ackOn  <= 1'b0;
                iState <= I_WACK;
                if (wrIdx != 2'h3)
                  wrIdx <= wrIdx + 2'h1;
                if (wrIdx == 2'h0)
                  cmd <= byteIn;
                else if (cmd == `TFI_CMD_RDPTR && wrIdx == 2'h1)
                begin
                  ptr    <= byteIn;
                  hiByte <= 1'b0;
                end
                else if (cmd == `TFI_REG_MASKWR)
                begin
                  wrData  <= byteIn;
                  wrStbLo <= (wrIdx == 2'h1);
                  wrStbHi <= (wrIdx == 2'h2);
                end
              end
            end
          end
          I_RD:
          begin
            if (sclRise)
              bitCnt <= bitCnt + 4'h1;
            else if (sclFall)
            begin
              if (bitCnt == 4'h8)
              begin
                sdaOe  <= 1'b0;
                iState <= I_RACK;
                hiByte <= ~hiByte; // RULE13
                if (hiByte)
                  ptr <= ptr + `TFI_PTR_STEP;
              end
              else
              begin
                txByte <= {txByte[6:0], 1'b0};
                sdaOe  <= ~txByte[6];
              end
            end
          end
          I_RACK:
          begin
            if (sclRise)
              nack <= sdaS;
            else if (sclFall)
            begin
              if (nack)
                iState <= I_IDLE;
              else
              begin
                txByte <= nextTx;
                sdaOe  <= ~nextTx[7];
                bitCnt <= 4'h0;
                iState <= I_RD;
              end
            end
          end
          default:
          begin
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Refresh tick for the measurement registers.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sampCnt  <= 16'h0000;
      sampTick <= 1'b0;
    end
    else
    begin
      sampTick <= (sampCnt == SAMPLE_LAST); // RULE18
      sampCnt  <= (sampCnt == SAMPLE_LAST) ? 16'h0000 : sampCnt + 16'h0001;
    end
  end

  // Operating mode follows the regulation loop input.
  always @*
  begin
    next_opMode = opMode;
    if (dacWord == setpointWord)
      next_opMode = `TFI_MODE_CV; // RULE1
    else if (dac_level(dacWord) < dac_level(setpointWord))
      next_opMode = (voltInst < kneeVoltage) ? `TFI_MODE_CC : `TFI_MODE_CP; // RULE1
  end

  // Instantaneous registers latch on the tick; codes above full range clamp.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      currInst <= curr_word(8'h00);
      voltInst <= 12'h000;
      opMode   <= `TFI_MODE_CV;
    end
    else if (sampTick)
    begin
      currInst <= curr_word((currSample > `TFI_CURR_FULL) ? `TFI_CURR_FULL
                                                          : currSample); // RULE14
      voltInst <= quantize(voltSample); // RULE12
      opMode   <= next_opMode;
    end
  end

  tfi_avg16 #(
    .W (12)
  ) u_avg_curr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (busSwitchOpen), // RULE17
    .push    (sampTick),
    .sample  ({4'h0, currInst[7:0]}),
    .mean    (cAvg)
  );

  tfi_avg16 #(
    .W (12)
  ) u_avg_volt (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (busSwitchOpen), // RULE17
    .push    (sampTick),
    .sample  (voltInst), // RULE16
    .mean    (vAvg)
  );

  // Fault sources by bit; bit 6 is the handshake wait, bit 8 a mode change.
  // Response settings do not gate the pulse: no-response faults still signal.
  wire                   modeEvt = sampTick && (next_opMode != opMode);
  wire [`TFI_MASK_W-1:0] events  = {modeEvt, faultEvent}; // RULE8 RULE7 RULE9
  wire [`TFI_MASK_W-1:0] hit     = events & maskEn; // RULE5
  wire                   lineIdle = !busBusy && sclS && sdaS;
  wire                   consume  = (nState == N_IDLE) && pending && lineIdle;

  // Enables drop on a trigger, but a low-byte rewrite in the same cycle re-arms; a high-byte one sets only bit 8.
  // The readback copy changes only on rewrite, never on a trigger.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      maskEn <= {`TFI_MASK_W{1'b0}};
      maskRd <= {`TFI_MASK_W{1'b0}};
    end
    else
    begin
      if (|hit)
        maskEn <= {`TFI_MASK_W{1'b0}}; // RULE5
      if (wrStbLo)
      begin
        maskEn <= {1'b0, wrData};
        maskRd <= {1'b0, wrData}; // RULE6
      end
      else if (wrStbHi)
      begin
        maskEn[`TFI_BIT_MODE] <= wrData[0];
        maskRd[`TFI_BIT_MODE] <= wrData[0]; // RULE6
      end
    end
  end

  // Clock-line pulse sequencer. A new fault sets pending even while it is
  // being consumed, so nothing is lost. A disable-output fault resets the
  // whole system elsewhere, which may cut a pulse short.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      pending  <= 1'b0;
      deferred <= 1'b0;
      nState   <= N_IDLE;
      nCnt     <= 16'h0000;
      sclOe    <= 1'b0; // RULE10
      sclOut   <= 1'b0;
    end
    else
    begin
      pending <= (pending & ~consume) | (|hit);
      if (|hit && !lineIdle)
        deferred <= 1'b1; // RULE4
      else if (consume)
        deferred <= 1'b0;
      case (nState)
        N_IDLE:
        begin
          nCnt <= 16'h0000;
          if (consume)
          begin
            nState <= deferred ? N_QUIET : N_PULL; // RULE3 RULE4
            sclOe  <= ~deferred; // RULE3
          end
        end
        N_QUIET:
        begin
          if (busBusy)
            nCnt <= 16'h0000;
          else if (nCnt == QUIET_LAST)
          begin
            nCnt   <= 16'h0000;
            nState <= N_PULL;
            sclOe  <= 1'b1; // RULE4
          end
          else
            nCnt <= nCnt + 16'h0001;
        end
        N_PULL:
        begin
          if (nCnt == PULL_LAST)
          begin
            nCnt   <= 16'h0000;
            nState <= N_IDLE;
            sclOe  <= 1'b0; // RULE3 RULE4
          end
          else
            nCnt <= nCnt + 16'h0001;
        end
        default:
        begin
          nState <= N_IDLE;
          sclOe  <= 1'b0;
        end
      endcase
    end
  end

endmodule // tfi_telemetry

/* File: rtl/tfi_map.vh */
`ifndef TFI_MAP_VH
`define TFI_MAP_VH
// Bus address of the device (7-bit form).
`define TFI_DEV_ADDR    7'h18
// Command that loads the telemetry read pointer.
`define TFI_CMD_RDPTR   8'h80
// Telemetry and mask register offsets.
`define TFI_REG_SETPT   8'h02
`define TFI_REG_CURR    8'h10
`define TFI_REG_VOLT    8'h12
`define TFI_REG_MODE    8'h16
`define TFI_REG_CAVG    8'h18
`define TFI_REG_VAVG    8'h1A
`define TFI_REG_DAC     8'h1C
`define TFI_REG_MASKRD  8'h22
`define TFI_REG_MASKWR  8'h2C
// Pointer step between word registers.
`define TFI_PTR_STEP    8'h02
// Timing, in nanoseconds.
`define TFI_CLK_NS      4
`define TFI_PULL_NS     50000
`define TFI_QUIET_NS    22000
`define TFI_SAMPLE_NS   100000
// Operating mode codes.
`define TFI_MODE_CV     2'h0
`define TFI_MODE_CC     2'h1
`define TFI_MODE_CP     2'h2
// Fault mask layout.
`define TFI_MASK_W      9
`define TFI_BIT_MODE    8
// Regulation DAC word: 5 V base, 100 mV per high count, 10 mV per low count.
`define TFI_DAC_BASE    13'h01F4
`define TFI_DAC_HI_STEP 13'h000A
// Current code full range (100 percent of sense threshold).
`define TFI_CURR_FULL   8'hC0
// Voltage report range limits and top-range step in 10 mV units.
`define TFI_V_LO        12'h2D0
`define TFI_V_MID       12'h3E8
`define TFI_V_HI_STEP   12'h00A
`endif

/* File: rtl/tfi_sync.v */
// Two-stage synchroniser for pins and other foreign-domain levels.
module tfi_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] stage1;

  // The first stage feeds only the second, to contain metastability.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      stage1 <= {W{1'b1}};
      dout   <= {W{1'b1}};
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // tfi_sync

/* File: rtl/tfi_avg16.v */
// Sixteen-sample rolling mean with a synchronous clear.
module tfi_avg16 #(
  parameter W = 12
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire         clear,
  input  wire         push,
  input  wire [W-1:0] sample,
  output wire [W-1:0] mean
);

  reg [W-1:0] hist [0:15];
  reg [3:0]   idx;
  reg [W+3:0] sum;
  integer     i;

  // Empty slots count as zero, so the mean climbs from zero after a clear.
  always @(posedge clk)
  begin
    if (sys_rst || clear)
    begin
      idx <= 4'h0;
      sum <= {(W+4){1'b0}};
      for (i = 0; i < 16; i = i + 1)
        hist[i] <= {W{1'b0}};
    end
    else if (push)
    begin
      sum       <= sum + {4'h0, sample} - {4'h0, hist[idx]};
      hist[idx] <= sample;
      idx       <= idx + 4'h1;
    end
  end

  // Dividing by sixteen keeps the resolution of the raw samples.
  assign mean = sum[W+3:4];

endmodule // tfi_avg16

/* File: verif/tfi_props.sv */
// Pin-level checks on the clock-line fault pull and on bus hygiene.
module tfi_props #(
  parameter SAMPLE_CYC = 50,
  parameter PULL_CYC   = 20
) (
  input wire        clk,
  input wire        sys_rst,
  input wire        sclIn,
  input wire        sclOut,
  input wire        sclOe,
  input wire        sdaIn,
  input wire        sdaOut,
  input wire        sdaOe,
  input wire        supplyOk,
  input wire [15:0] dacWord,
  input wire [15:0] setpointWord,
  input wire [1:0]  opMode
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [15:0] pullCnt;
  reg [15:0] eqCnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Length of the pull so far, and how long the DAC word has matched the setpoint.
  always @(posedge clk)
  begin
    if (sys_rst || !sclOe)
      pullCnt <= 16'h0000;
    else
      pullCnt <= pullCnt + 16'h0001;
    if (sys_rst || dacWord != setpointWord)
      eqCnt <= 16'h0000;
    else if (eqCnt != 16'hFFFF)
      eqCnt <= eqCnt + 16'h0001;
  end
  // A pull may only start on an idle bus, or it would corrupt a host transfer.
  a_pull_width: assert property ($fell(sclOe) |-> pullCnt == PULL_CYC)
    else $error("Fault pull has the wrong length.");
  a_pull_idle: assert property ($rose(sclOe) |-> $past(sclIn) && $past(sdaIn))
    else $error("Fault pull began on a busy bus.");
  a_pull_level: assert property (sclOe |-> !sclOut)
    else $error("Clock line driven high.");
  a_sda_level: assert property (sdaOe |-> !sdaOut)
    else $error("Data line driven high.");
  a_sda_steady: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("Data line moved while the clock was high.");
  a_pull_no_ack: assert property (sclOe |-> !sdaOe)
    else $error("Data line held during a fault pull.");
  a_supply_mute: assert property (!supplyOk [*5] |-> !sdaOe)
    else $error("Bus answered with the supply low.");
  a_mode_code: assert property (opMode != 2'h3)
    else $error("Operating mode code unused value.");
  a_mode_cv: assert property (eqCnt > SAMPLE_CYC + 3 |-> opMode == 2'h0)
    else $error("Matching DAC word without voltage mode.");
endmodule // tfi_props

bind tfi_telemetry tfi_props #(
  .SAMPLE_CYC(SAMPLE_CYC),
  .PULL_CYC(PULL_CYC)
) tfi_props_i (
  .clk(clk),
  .sys_rst(sys_rst),
  .sclIn(sclIn),
  .sclOut(sclOut),
  .sclOe(sclOe),
  .sdaIn(sdaIn),
  .sdaOut(sdaOut),
  .sdaOe(sdaOe),
  .supplyOk(supplyOk),
  .dacWord(dacWord),
  .setpointWord(setpointWord),
  .opMode(opMode)
);

/* File: verif/tfi_host_model.sv */
`include "tfi_map.vh"
// Host bus master; released lines float high through the pull-ups.
module tfi_host_model (
  input  wire clk,
  input  wire sclLine,
  input  wire sdaLine,
  output reg  sclDrv,
  output reg  sdaDrv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial sclDrv = 1'b1;
  initial sdaDrv = 1'b1;
  // Three cycles are a quarter of the 48 ns bus clock.
  task automatic q();
    repeat (3) @(posedge clk);
  endtask
  task automatic half();
    q();
    q();
  endtask
  // Data moves mid-low so it never races the clock edge.
  task automatic put_bit(input logic b);
    q();
    sdaDrv <= b;
    q();
    sclDrv <= 1'b1;
    half();
    sclDrv <= 1'b0;
  endtask
  task automatic get_bit(output logic b);
    q();
    sdaDrv <= 1'b1;
    q();
    sclDrv <= 1'b1;
    q();
    b = sdaLine;
    q();
    sclDrv <= 1'b0;
  endtask
  task automatic start();
    sdaDrv <= 1'b0;
    half();
    sclDrv <= 1'b0;
  endtask
  task automatic stop();
    q();
    sdaDrv <= 1'b0;
    q();
    sclDrv <= 1'b1;
    half();
    sdaDrv <= 1'b1;
    half();
  endtask
  task automatic send(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--)
      put_bit(b[i]);
    get_bit(nak);
  endtask
  task automatic recv(input logic last, output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      get_bit(b[i]);
    put_bit(last);
  endtask
  // Command, low byte, optional high byte; nak gathers every refusal.
  task automatic wr_cmd(input logic [7:0] cmd, input logic [15:0] d, input logic two,
                        output logic nak);
    logic [3:0] a;
    a = 4'h0;
    start();
    send({`TFI_DEV_ADDR, 1'b0}, a[0]);
    send(cmd, a[1]);
    send(d[7:0], a[2]);
    if (two)
      send(d[15:8], a[3]);
    stop();
    nak = |a;
  endtask
  task automatic rd_word(input logic [7:0] off, output logic [15:0] w, output logic nak);
    logic a;
    wr_cmd(`TFI_CMD_RDPTR, {8'h00, off}, 1'b0, nak);
    start();
    send({`TFI_DEV_ADDR, 1'b1}, a);
    recv(1'b0, w[7:0]);
    recv(1'b1, w[15:8]);
    stop();
    nak = nak | a;
  endtask
endmodule // tfi_host_model

/* File: verif/tb_telemetry_fault_interrupt.sv */
`include "tfi_map.vh"
module tb_telemetry_fault_interrupt;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S = 50;
  localparam int P = 20;
  localparam int Q = 10;
  logic        clk;
  logic        sys_rst;
  logic        supplyOk;
  logic        busSwitchOpen;
  logic [15:0] dacWord;
  logic [15:0] setpointWord;
  logic [11:0] kneeVoltage;
  logic [11:0] voltSample;
  logic [7:0]  currSample;
  logic [7:0]  faultEvent;
  wire         sclOut;
  wire         sclOe;
  wire         sdaOut;
  wire         sdaOe;
  wire  [1:0]  opMode;
  wire         hostScl;
  wire         hostSda;
  wire         sclIn;
  wire         sdaIn;
  int          miscompares;
  int          checksDone;
  int          n;
  logic [15:0] w;
  logic        a;
  // Pulled-up lines: low while either party pulls.
  assign sclIn = hostScl & ~(sclOe & ~sclOut);
  assign sdaIn = hostSda & ~(sdaOe & ~sdaOut);
  tfi_telemetry #(.SAMPLE_CYC(S), .PULL_CYC(P), .QUIET_CYC(Q)) tfi_telemetry_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .sclIn(sclIn),
    .sclOut(sclOut),
    .sclOe(sclOe),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .supplyOk(supplyOk),
    .dacWord(dacWord),
    .setpointWord(setpointWord),
    .kneeVoltage(kneeVoltage),
    .voltSample(voltSample),
    .currSample(currSample),
    .busSwitchOpen(busSwitchOpen),
    .faultEvent(faultEvent),
    .opMode(opMode)
  );
  tfi_host_model tfi_host_model_i (
    .clk(clk),
    .sclLine(sclIn),
    .sdaLine(sdaIn),
    .sclDrv(hostScl),
    .sdaDrv(hostSda)
  );
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic report_and_stop();
    if (miscompares == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic rd(input logic [7:0] off, input logic [15:0] exp);
    tfi_host_model_i.rd_word(off, w, a);
    check_bit(a, 1'b0);
    check_word(w, exp);
  endtask
  task automatic mask(input logic [15:0] m);
    tfi_host_model_i.wr_cmd(`TFI_REG_MASKWR, m, 1'b1, a);
    check_bit(a, 1'b0);
  endtask
  task automatic fire(input int i);
    faultEvent <= 8'h01 << i;
    @(posedge clk);
    faultEvent <= 8'h00;
  endtask
  // Counts pulled cycles; a prompt pull fits wholly inside the window.
  task automatic pulse(input int win, input int want);
    int k;
    k = 0;
    repeat (win)
    begin
      @(posedge clk);
      k += int'(sclOe !== 1'b0);
    end
    check_word(16'(k), 16'(want));
  endtask
  // A hang is cut short well beyond the expected length of the run.
  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
  initial
  begin
    sys_rst <= 1'b1;
    supplyOk <= 1'b1;
    busSwitchOpen <= 1'b0;
    dacWord <= 16'h0A05;
    setpointWord <= 16'h0A05;
    kneeVoltage <= 12'h3E8;
    voltSample <= 12'h1A8;
    currSample <= 8'h40;
    faultEvent <= 8'h00;
    miscompares = 0;
    checksDone = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(`TFI_REG_MASKRD, 16'h0000);
    tfi_host_model_i.start();
    tfi_host_model_i.send(8'h32, a);
    tfi_host_model_i.stop();
    check_bit(a, 1'b1);
    // Telemetry words, then steps that coarsen with range and a clamped code.
    repeat (2 * S) @(posedge clk);
    rd(`TFI_REG_VOLT, 16'h01A8);
    rd(`TFI_REG_CURR, 16'h8040);
    check_word({1'b0, w[14:0]}, 16'h0040);
    rd(`TFI_REG_DAC, 16'h0A05);
    rd(`TFI_REG_SETPT, 16'h0A05);
    check_word({14'h0000, opMode}, {14'h0000, `TFI_MODE_CV});
    voltSample <= 12'h2D1;
    currSample <= 8'hFF;
    repeat (S + 4) @(posedge clk);
    rd(`TFI_REG_VOLT, 16'h02D0);
    rd(`TFI_REG_CURR, 16'h80C0);
    voltSample <= 12'h3E9;
    repeat (S + 4) @(posedge clk);
    rd(`TFI_REG_VOLT, 16'h03E8);
    // Averages read zero while the switch is open, then settle.
    voltSample <= 12'h3E8;
    busSwitchOpen <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`TFI_REG_CAVG, 16'h8000);
    rd(`TFI_REG_VAVG, 16'h0000);
    busSwitchOpen <= 1'b0;
    repeat (17 * S) @(posedge clk);
    rd(`TFI_REG_VAVG, 16'h03E8);
    rd(`TFI_REG_CAVG, 16'h80C0);
    // Lower DAC word: current mode under the knee, power mode above it.
    dacWord <= 16'h0500;
    voltSample <= 12'h1F4;
    repeat (2 * S + 2) @(posedge clk);
    check_word({14'h0000, opMode}, {14'h0000, `TFI_MODE_CC});
    mask(16'h0100);
    kneeVoltage <= 12'h100;
    pulse(S + P + 8, P);
    check_word({14'h0000, opMode}, {14'h0000, `TFI_MODE_CP});
    // Each fault armed alone and fired on an idle bus.
    for (int i = 0; i < 8; i++)
    begin
      mask(16'h0001 << i);
      fire(i);
      pulse(P + 8, P);
    end
    rd(`TFI_REG_MASKRD, 16'h0080);
    fire(7);
    pulse(P + 8, 0);
    mask(16'h01FF);
    rd(`TFI_REG_MASKRD, 16'h01FF);
    mask(16'h0002);
    fire(0);
    pulse(P + 8, 0);
    // A fault in mid-transfer waits for the stop and the quiet gap.
    mask(16'h0001);
    fork
      rd(`TFI_REG_VOLT, 16'h01F4);
      begin
        repeat (60) @(posedge clk);
        fire(0);
      end
    join
    n = 0;
    while (sclOe !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    check_bit(n >= Q - 6 && n <= Q + 2, 1'b1);
    repeat (P + 4) @(posedge clk);
    // With the supply low the bus is ignored and the mask kept.
    supplyOk <= 1'b0;
    repeat (8) @(posedge clk);
    tfi_host_model_i.wr_cmd(`TFI_REG_MASKWR, 16'h0003, 1'b1, a);
    check_bit(a, 1'b1);
    supplyOk <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`TFI_REG_MASKRD, 16'h0001);
    report_and_stop();
  end
endmodule // tb_telemetry_fault_interrupt
